// ### tecr_pkg.sv
package tecr_pkg;
  // Register byte addresses on APB
  localparam logic [11:0] TECR_ADDR_CONTROL   = 12'h000;  // Timer control
  localparam logic [11:0] TECR_ADDR_COUNT     = 12'h004;  // Counter, high:low bytes
  localparam logic [11:0] TECR_ADDR_COMPARE   = 12'h008;  // Compare period value
  localparam logic [11:0] TECR_ADDR_GATE      = 12'h00C;  // Gate control
  localparam logic [11:0] TECR_ADDR_IRQ_STAT  = 12'h010;  // Sticky status, write one clears
  localparam logic [11:0] TECR_ADDR_IRQ_MASK  = 12'h014;  // Interrupt mask
  // Timer control fields
  localparam int TECR_CS_MSB    = 7;  // Clock source select, upper bit
  localparam int TECR_CS_LSB    = 6;  // Clock source select, lower bit
  localparam int TECR_PS_MSB    = 5;  // Prescale select, upper bit
  localparam int TECR_PS_LSB    = 4;  // Prescale select, lower bit
  localparam int TECR_OSCEN_BIT = 3;  // Dedicated oscillator enable
  localparam int TECR_SYNC_BIT  = 2;  // Synchronisation bypass
  localparam int TECR_ON_BIT    = 0;  // Timer on
  localparam logic [7:0] TECR_CONTROL_MASK  = 8'hFD;  // Bit 1 unimplemented
  localparam logic [7:0] TECR_CONTROL_RESET = 8'h00;
  // Clock source codes
  localparam logic [1:0] TECR_CS_INSTR = 2'h0;  // System clock over four
  localparam logic [1:0] TECR_CS_SYS   = 2'h1;  // System clock
  localparam logic [1:0] TECR_CS_PIN   = 2'h2;  // External pin or dedicated oscillator
  localparam logic [1:0] TECR_CS_SENSE = 2'h3;  // Sensing oscillator
  // Gate control fields
  localparam int TECR_GE_BIT   = 7;  // Gate enable
  localparam int TECR_GPOL_BIT = 6;  // Gate polarity
  localparam int TECR_GTM_BIT  = 5;  // Toggle enable
  localparam int TECR_GSPM_BIT = 4;  // Single pulse enable
  localparam int TECR_GGO_BIT  = 3;  // Single pulse armed
  localparam int TECR_GVAL_BIT = 2;  // Gate value, read only
  localparam logic [7:0] TECR_GATE_WMASK = 8'hF8;
  // Status bits
  localparam int TECR_ST_OVF  = 0;  // Counter overflow
  localparam int TECR_ST_GATE = 1;  // Gate event
  localparam int TECR_ST_TRIG = 2;  // Special event trigger
  localparam int TECR_NUM_ST  = 3;
  // Instruction clock divide
  localparam logic [1:0] TECR_INSTR_DIV_LAST = 2'h3;
  // Counter wrap value
  localparam logic [15:0] TECR_COUNT_MAX = 16'hFFFF;
endpackage

// ### tecr_edge_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser with optional bypass and rising edge detect
module tecr_edge_sync (
  input  wire logic ref_clk,      // System clock
  input  wire logic rst,          // Asynchronous reset, active high
  input  wire logic raw_in,       // Asynchronous level
  input  wire logic bypass,       // Skip synchroniser stages
  output logic      level_out,    // Selected level
  output logic      rise_pulse    // One cycle on rising edge
);
  logic meta_ff;   // First stage, read only by second
  logic sync_ff;   // Second stage
  logic prev_ff;   // Last level for edge detect

  // Synchroniser chain
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= raw_in;
      sync_ff <= meta_ff;
    end
  end

  // Bypass takes the pin directly
  assign level_out = bypass ? raw_in : sync_ff;

  // Edge history
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= level_out;
    end
  end

  assign rise_pulse = level_out & ~prev_ff;
endmodule

// ### tecr_timer.sv
`timescale 1ns/1ps
module tecr_timer
  import tecr_pkg::*;
#(
  parameter int PS_WIDTH = 3  // Prescale counter width
) (
  input  wire logic        ref_clk,              // System clock, 100 MHz
  input  wire logic        rst,                  // Asynchronous reset
  input  wire logic        psel,                 // APB select
  input  wire logic        penable,              // APB enable
  input  wire logic        pwrite,               // APB direction
  input  wire logic [11:0] paddr,                // APB byte address
  input  wire logic [31:0] pwdata,               // APB write data
  output logic      [31:0] prdata,               // APB read data
  output logic             pready,               // APB ready
  output logic             pslverr,              // APB error
  input  wire logic        external_clock_pin,   // External count clock
  input  wire logic        dedicated_osc_clk,    // Dedicated oscillator output
  input  wire logic        sensing_oscillator,   // Sensing oscillator output
  input  wire logic        gate_input_pin,       // Gate input
  input  wire logic        special_event_trig,   // Compare match trigger pulse
  output logic             compare_match,        // Match pulse to compare unit
  output logic             irq                   // Level interrupt
);
  import tecr_pkg::*;

  // Elaboration check on prescale counter width
  if (PS_WIDTH < 3) begin : g_ps_width_check
    $error("PS_WIDTH must be at least 3");
  end

  // Timer control, bit 1 held zero
  logic [7:0]  timer_control_ff;
  // Gate control writable bits
  logic [7:0]  gate_control_ff;
  // Counter bytes
  logic [7:0]  count_high_byte_ff;
  logic [7:0]  count_low_byte_ff;
  // Compare period
  logic [7:0]  compare_value_high_ff;
  logic [7:0]  compare_value_low_ff;
  // Interrupt status and mask
  logic [TECR_NUM_ST-1:0] irq_stat_ff;
  logic [TECR_NUM_ST-1:0] irq_mask_ff;
  // Instruction clock divider
  logic [1:0]  instr_div_ff;
  // Prescaler
  logic [PS_WIDTH-1:0] ps_cnt_ff;
  // Gate path state
  logic        gate_toggle_ff;   // Toggle flip-flop
  logic        gate_value_ff;    // Registered gate value
  logic        gate_prev_in_ff;  // Gate input history
  logic        gate_src_prev_ff; // Gate source history
  logic        pulse_run_ff;     // Single pulse window open
  // Bus outputs and match pulse
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        compare_match_ff;
  logic        irq_ff;

  // Register-facing fields
  logic [1:0] clock_source_select;
  logic [1:0] prescale_select;
  logic       dedicated_osc_enable;
  logic       sync_bypass;
  logic       timer_on;
  logic       gate_enable;
  logic       gate_polarity;
  logic       gate_toggle_enable;
  logic       single_pulse_enable;
  logic       single_pulse_armed;
  logic       gate_value;

  assign clock_source_select  = timer_control_ff[TECR_CS_MSB:TECR_CS_LSB];
  assign prescale_select      = timer_control_ff[TECR_PS_MSB:TECR_PS_LSB];
  assign dedicated_osc_enable = timer_control_ff[TECR_OSCEN_BIT];
  assign sync_bypass          = timer_control_ff[TECR_SYNC_BIT];
  assign timer_on             = timer_control_ff[TECR_ON_BIT];
  assign gate_enable          = gate_control_ff[TECR_GE_BIT];
  assign gate_polarity        = gate_control_ff[TECR_GPOL_BIT];
  assign gate_toggle_enable   = gate_control_ff[TECR_GTM_BIT];
  assign single_pulse_enable  = gate_control_ff[TECR_GSPM_BIT];
  assign single_pulse_armed   = gate_control_ff[TECR_GGO_BIT];
  assign gate_value           = gate_value_ff;

  // Bus decode
  logic acc_wr;
  logic acc_rd;
  assign acc_wr = psel & penable & pwrite & pready_ff;
  assign acc_rd = psel & penable & ~pwrite & pready_ff;

  // Address compare helper
  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    return a == r;
  endfunction

  // Known address check
  function automatic logic mapped(input logic [11:0] a);
    return hit(a, TECR_ADDR_CONTROL) | hit(a, TECR_ADDR_COUNT) |
           hit(a, TECR_ADDR_COMPARE) | hit(a, TECR_ADDR_GATE) |
           hit(a, TECR_ADDR_IRQ_STAT) | hit(a, TECR_ADDR_IRQ_MASK);
  endfunction

  // External pin through synchroniser unless bypassed
  logic ext_raw;
  logic ext_level;
  logic ext_rise;
  assign ext_raw = dedicated_osc_enable ? dedicated_osc_clk : external_clock_pin;
  tecr_edge_sync u_ext_sync (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .raw_in     (ext_raw),
    .bypass     (sync_bypass),
    .level_out  (ext_level),
    .rise_pulse (ext_rise)
  );

  // Sensing oscillator always synchronised
  logic sense_rise;
  tecr_edge_sync u_sense_sync (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .raw_in     (sensing_oscillator),
    .bypass     (1'b0),
    .level_out  (),
    .rise_pulse (sense_rise)
  );

  // Gate input synchronised
  logic gate_in_level;
  tecr_edge_sync u_gate_sync (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .raw_in     (gate_input_pin),
    .bypass     (1'b0),
    .level_out  (gate_in_level),
    .rise_pulse ()
  );

  // Instruction clock tick every fourth system clock
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      instr_div_ff <= 2'h0;
    end else begin
      instr_div_ff <= instr_div_ff + 2'h1;
    end
  end

  // Source selection
  logic src_tick;
  always_comb begin
    unique case (clock_source_select)
      TECR_CS_INSTR: src_tick = (instr_div_ff == TECR_INSTR_DIV_LAST);
      TECR_CS_SYS:   src_tick = 1'b1;
      TECR_CS_PIN:   src_tick = ext_rise;
      TECR_CS_SENSE: src_tick = sense_rise;
    endcase
  end

  // Prescaler, ticks on wrap of selected width
  logic [PS_WIDTH-1:0] ps_last;
  logic                ps_tick;
  always_comb begin
    ps_last = '0;
    unique case (prescale_select)
      2'h0: ps_last = PS_WIDTH'(0);
      2'h1: ps_last = PS_WIDTH'(1);
      2'h2: ps_last = PS_WIDTH'(3);
      2'h3: ps_last = PS_WIDTH'(7);
    endcase
  end
  assign ps_tick = src_tick & timer_on & (ps_cnt_ff >= ps_last);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ps_cnt_ff <= '0;
    end else if (!timer_on) begin
      ps_cnt_ff <= '0;
    end else if (src_tick) begin
      ps_cnt_ff <= (ps_cnt_ff >= ps_last) ? '0 : ps_cnt_ff + PS_WIDTH'(1);
    end
  end

  // Gate polarity, toggle and value
  logic gate_pol_in;
  logic gate_pol_rise;
  logic gate_src;
  logic gate_fall;
  assign gate_pol_in   = gate_in_level ^ ~gate_polarity;
  assign gate_pol_rise = gate_pol_in & ~gate_prev_in_ff;
  assign gate_src      = gate_toggle_enable ? gate_toggle_ff : gate_pol_in;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gate_prev_in_ff  <= 1'b0;
      gate_src_prev_ff <= 1'b0;
    end else begin
      gate_prev_in_ff  <= gate_pol_in;
      gate_src_prev_ff <= gate_src;
    end
  end

  // Toggle flip-flop, held clear when toggle off or timer off
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gate_toggle_ff <= 1'b0;
    end else if (!gate_toggle_enable || !timer_on) begin
      gate_toggle_ff <= 1'b0;
    end else if (gate_pol_rise) begin
      gate_toggle_ff <= ~gate_toggle_ff;
    end
  end

  // Single pulse window opens on gate rise while armed
  logic gate_rise_src;
  assign gate_rise_src = gate_src & ~gate_src_prev_ff & ~pulse_run_ff;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pulse_run_ff <= 1'b0;
    end else if (!single_pulse_enable || !single_pulse_armed) begin
      pulse_run_ff <= 1'b0;
    end else if (gate_rise_src) begin
      pulse_run_ff <= 1'b1;
    end
  end

  // Gate value as seen by the counter
  logic nxt_gate_value;
  always_comb begin
    if (single_pulse_enable) begin
      nxt_gate_value = single_pulse_armed & (pulse_run_ff | gate_rise_src) & gate_src;
    end else begin
      nxt_gate_value = gate_src;
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gate_value_ff <= 1'b0;
    end else begin
      gate_value_ff <= nxt_gate_value;
    end
  end
  assign gate_fall = gate_value_ff & ~nxt_gate_value;

  // Count qualification
  logic count_en;
  logic cnt_wr;
  logic [15:0] count_now;
  logic at_period;
  assign count_en  = ps_tick & (~gate_enable | gate_value_ff);
  assign cnt_wr    = acc_wr & hit(paddr, TECR_ADDR_COUNT);
  assign count_now = {count_high_byte_ff, count_low_byte_ff};
  assign at_period = count_now == {compare_value_high_ff, compare_value_low_ff};

  // Counter; write first, then trigger clear, then increment
  logic [15:0] nxt_count;
  logic        ovf_evt;
  always_comb begin
    nxt_count = count_now;
    ovf_evt   = 1'b0;
    if (cnt_wr) begin
      nxt_count = pwdata[15:0];
    end else if (special_event_trig) begin
      nxt_count = 16'h0000;
    end else if (count_en) begin
      nxt_count = count_now + 16'h0001;
      ovf_evt   = (count_now == TECR_COUNT_MAX);
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_high_byte_ff <= 8'h00;
      count_low_byte_ff  <= 8'h00;
    end else begin
      count_high_byte_ff <= nxt_count[15:8];
      count_low_byte_ff  <= nxt_count[7:0];
    end
  end

  // Match pulse to compare unit, once per entry
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      compare_match_ff <= 1'b0;
    end else begin
      compare_match_ff <= (nxt_count == {compare_value_high_ff, compare_value_low_ff}) &
                          ~at_period;
    end
  end

  // Timer control register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timer_control_ff <= TECR_CONTROL_RESET;
    end else if (acc_wr && hit(paddr, TECR_ADDR_CONTROL)) begin
      timer_control_ff <= pwdata[7:0] & TECR_CONTROL_MASK;
    end
  end

  // Compare value register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      compare_value_high_ff <= 8'h00;
      compare_value_low_ff  <= 8'h00;
    end else if (acc_wr && hit(paddr, TECR_ADDR_COMPARE)) begin
      compare_value_high_ff <= pwdata[15:8];
      compare_value_low_ff  <= pwdata[7:0];
    end
  end

  // Gate control; fall clears armed bit, set by write wins
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gate_control_ff <= 8'h00;
    end else begin
      if (acc_wr && hit(paddr, TECR_ADDR_GATE)) begin
        gate_control_ff <= pwdata[7:0] & TECR_GATE_WMASK;
        if (!pwdata[TECR_GSPM_BIT]) begin
          gate_control_ff[TECR_GGO_BIT] <= 1'b0;
        end
      end else if (single_pulse_enable && gate_fall) begin
        gate_control_ff[TECR_GGO_BIT] <= 1'b0;
      end
    end
  end

  // Sticky status; new event beats write-one clear
  logic [TECR_NUM_ST-1:0] st_evt;
  logic [TECR_NUM_ST-1:0] st_clr;
  always_comb begin
    st_evt = '0;
    st_evt[TECR_ST_OVF]  = ovf_evt;
    st_evt[TECR_ST_GATE] = gate_fall;
    st_evt[TECR_ST_TRIG] = special_event_trig;
    st_clr = (acc_wr && hit(paddr, TECR_ADDR_IRQ_STAT)) ? pwdata[TECR_NUM_ST-1:0] : '0;
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~st_clr) | st_evt;
    end
  end

  // Interrupt mask
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_mask_ff <= '0;
    end else if (acc_wr && hit(paddr, TECR_ADDR_IRQ_MASK)) begin
      irq_mask_ff <= pwdata[TECR_NUM_ST-1:0];
    end
  end

  // Interrupt output
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // APB ready: one wait state, answer in access cycle two
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= psel & penable & ~pready_ff;
    end
  end

  // Read data mux, loaded with ready
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit(paddr, TECR_ADDR_CONTROL)) begin
      rd_mux[7:0] = timer_control_ff;
    end else if (hit(paddr, TECR_ADDR_COUNT)) begin
      rd_mux[15:0] = count_now;
    end else if (hit(paddr, TECR_ADDR_COMPARE)) begin
      rd_mux[15:0] = {compare_value_high_ff, compare_value_low_ff};
    end else if (hit(paddr, TECR_ADDR_GATE)) begin
      rd_mux[7:0] = gate_control_ff;
      rd_mux[TECR_GVAL_BIT] = gate_value;
    end else if (hit(paddr, TECR_ADDR_IRQ_STAT)) begin
      rd_mux[TECR_NUM_ST-1:0] = irq_stat_ff;
    end else if (hit(paddr, TECR_ADDR_IRQ_MASK)) begin
      rd_mux[TECR_NUM_ST-1:0] = irq_mask_ff;
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel && penable && !pready_ff && !pwrite) begin
      prdata_ff <= rd_mux;
    end
  end

  // Error on unmapped address
  logic pslverr_ff;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pslverr_ff <= 1'b0;
    end else begin
      pslverr_ff <= psel & penable & ~pready_ff & ~mapped(paddr);
    end
  end

  assign prdata        = prdata_ff;
  assign pready        = pready_ff;
  assign pslverr       = pslverr_ff;
  assign compare_match = compare_match_ff;
  assign irq           = irq_ff;
  // Reads have no side effects
  logic unused_rd;
  assign unused_rd = acc_rd;
endmodule

// ### tecr_timer_monitor.sv
`timescale 1ns/1ps
// Port-level checker for the timer block
module tecr_timer_monitor
  import tecr_pkg::*;
(
  input wire logic        ref_clk,        // System clock
  input wire logic        rst,            // Async reset
  input wire logic        psel,           // APB select
  input wire logic        penable,        // APB enable
  input wire logic        pwrite,         // APB direction
  input wire logic [11:0] paddr,          // APB address
  input wire logic [31:0] prdata,         // APB read data
  input wire logic        pready,         // APB ready
  input wire logic        pslverr,        // APB error
  input wire logic        compare_match   // Match pulse
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Exactly one wait state per access
  a_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not after one wait state");
  // Ready is a single-cycle pulse
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  // No answer without an access phase
  a_idle_quiet: assert property (!(psel && penable) |=> !pready)
    else $error("pready without access");
  // Error only comes with ready
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  // Refused reads return zero
  a_unmapped_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  // Mapped words are never refused
  a_mapped_ok: assert property (pready && paddr <= TECR_ADDR_IRQ_MASK && paddr[1:0] == 2'h0
    |-> !pslverr) else $error("mapped access refused");
  // Control reads: bit 1 and upper bits zero
  a_control_bit1: assert property (pready && !pwrite && paddr == TECR_ADDR_CONTROL
    |-> prdata[31:8] == 24'h0 && !prdata[1]) else $error("control unused bits set");
  // Match is a pulse of one cycle, never held into the next
  a_match_pulse: assert property (compare_match |=> !compare_match)
    else $error("compare match longer than one cycle");
endmodule

bind tecr_timer tecr_timer_monitor u_tecr_timer_monitor (
  .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .compare_match(compare_match));

// ### tecr_cmp_model.sv
`timescale 1ns/1ps
// Compare unit model: answers a match with a trigger pulse
module tecr_cmp_model (
  input  wire logic ref_clk,           // System clock
  input  wire logic rst,               // Async reset
  input  wire logic compare_match,     // Match from timer
  input  wire logic slow,              // One extra cycle of latency
  input  wire logic force_trig,        // Commanded trigger
  input  wire logic collide,           // Fire during a write answer
  input  wire logic write_done,        // Write being answered
  output logic      special_event_trig // Trigger to timer
);
  logic stg1_ff;  // First latency stage
  logic stg2_ff;  // Second latency stage
  // Delay the match by one or two cycles
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stg1_ff <= 1'b0;
      stg2_ff <= 1'b0;
    end else begin
      stg1_ff <= compare_match;
      stg2_ff <= stg1_ff;
    end
  end
  // Prompt or slow answer, commanded pulse, or collision with a write
  assign special_event_trig = (slow ? stg2_ff : stg1_ff) | force_trig | (collide & write_done);
endmodule

// ### tecr_timer_test.sv
`timescale 1ns/1ps
// Self-checking bench for the timer block
module tecr_timer_test;
  import tecr_pkg::*;
  logic        ref_clk;   // System clock
  logic        rst;       // Reset
  logic        psel;      // APB select
  logic        penable;   // APB enable
  logic        pwrite;    // APB direction
  logic [11:0] paddr;     // APB address
  logic [31:0] pwdata;    // APB write data
  logic [31:0] prdata;    // APB read data
  logic        pready;    // APB ready
  logic        pslverr;   // APB error
  logic        last_err;  // Error of last access
  logic        ext_clk;   // External pin clock
  logic        osc_clk;   // Dedicated oscillator
  logic        sense_clk; // Sensing oscillator
  logic        gate_pin;  // Gate input
  logic        trig;      // Trigger to timer
  logic        match;     // Match from timer
  logic        irq;       // Interrupt
  logic        slow;      // Partner latency select
  logic        force_trig;// Commanded trigger
  logic        collide;   // Trigger on write answer
  int          n_errors;  // Mismatches
  int          n_checks;  // Comparisons

  tecr_timer u_tecr_timer (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_clock_pin(ext_clk), .dedicated_osc_clk(osc_clk),
    .sensing_oscillator(sense_clk), .gate_input_pin(gate_pin), .special_event_trig(trig),
    .compare_match(match), .irq(irq));
  tecr_cmp_model u_tecr_cmp_model (.ref_clk(ref_clk), .rst(rst), .compare_match(match),
    .slow(slow), .force_trig(force_trig), .collide(collide),
    .write_done(pready & pwrite & psel & penable), .special_event_trig(trig));

  // Clock
  always #5 ref_clk = ~ref_clk;

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Range compare
  task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    n_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, lo);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int k;
    k = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, pready, 1'b1);
    end
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Write shortcut
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  // Pulse one source pin n times
  task automatic pulse(input int sel, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      ext_clk <= (sel == 0 || sel == 2);
      osc_clk <= (sel == 1);
      sense_clk <= (sel == 3);
      repeat (4) @(posedge ref_clk);
      ext_clk <= 1'b0;
      osc_clk <= 1'b0;
      sense_clk <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
  endtask

  // Control reset value, unused bit, refused address
  task automatic t_regs;
    logic [31:0] q;
    apb(1'b0, TECR_ADDR_CONTROL, 32'h0, q);
    chk(q, 32'h0);
    wr(TECR_ADDR_CONTROL, 32'hFE);
    apb(1'b0, TECR_ADDR_CONTROL, 32'h0, q);
    chk(q, 32'hFC);
    wr(TECR_ADDR_CONTROL, 32'h0);
    apb(1'b0, 12'h0FC, 32'h0, q);
    chk({31'h0, last_err}, 32'h1);
    wr(TECR_ADDR_COMPARE, 32'hFFFF);
  endtask
  // Pin, dedicated, bypassed pin and sensing sources
  task automatic t_source;
    logic [7:0] ctl [4];
    logic [31:0] q;
    ctl = '{8'h81, 8'h89, 8'h85, 8'hC1};
    for (int i = 0; i < 4; i++) begin
      wr(TECR_ADDR_COUNT, 32'h0);
      wr(TECR_ADDR_CONTROL, {24'h0, ctl[i]});
      pulse(i, 5);
      repeat (8) @(posedge ref_clk);
      wr(TECR_ADDR_CONTROL, 32'h0);
      apb(1'b0, TECR_ADDR_COUNT, 32'h0, q);
      chk(q, 32'h5);
    end
  endtask
  // Instruction and system clock through every prescale
  task automatic t_prescale;
    logic [31:0] q;
    int e;
    for (int cs = 0; cs < 2; cs++) begin
      for (int ps = 0; ps < 4; ps++) begin
        e = 100 / ((cs == 0 ? 4 : 1) << ps);
        wr(TECR_ADDR_COUNT, 32'h0);
        wr(TECR_ADDR_CONTROL, 32'(cs * 64 + ps * 16 + 1));
        repeat (96) @(posedge ref_clk);
        wr(TECR_ADDR_CONTROL, 32'h0);
        apb(1'b0, TECR_ADDR_COUNT, 32'h0, q);
        chk_rng(q, 32'(e - 2), 32'(e + 2));
      end
    end
  endtask
  // Compare period, trigger clear, collision with a write
  task automatic t_trigger;
    logic [31:0] q;
    for (int s = 0; s < 2; s++) begin
      slow <= s[0];
      wr(TECR_ADDR_IRQ_STAT, 32'h7);
      wr(TECR_ADDR_COMPARE, 32'h5);
      wr(TECR_ADDR_COUNT, 32'h0);
      wr(TECR_ADDR_IRQ_MASK, 32'h4);
      wr(TECR_ADDR_CONTROL, 32'h01);
      repeat (200) @(posedge ref_clk);
      wr(TECR_ADDR_CONTROL, 32'h0);
      apb(1'b0, TECR_ADDR_COUNT, 32'h0, q);
      chk_rng(q, 32'h0, 32'h5);
      apb(1'b0, TECR_ADDR_IRQ_STAT, 32'h0, q);
      chk(q, 32'h4);
      chk({31'h0, irq}, 32'h1);
    end
    wr(TECR_ADDR_IRQ_STAT, 32'h4);
    wr(TECR_ADDR_COUNT, 32'h1234);
    @(posedge ref_clk);
    force_trig <= 1'b1;
    @(posedge ref_clk);
    force_trig <= 1'b0;
    apb(1'b0, TECR_ADDR_COUNT, 32'h0, q);
    chk(q, 32'h0);
    collide <= 1'b1;
    wr(TECR_ADDR_COUNT, 32'hABCD);
    collide <= 1'b0;
    apb(1'b0, TECR_ADDR_COUNT, 32'h0, q);
    chk(q, 32'hABCD);
    apb(1'b0, TECR_ADDR_IRQ_STAT, 32'h0, q);
    chk(q, 32'h4);
    wr(TECR_ADDR_IRQ_STAT, 32'h7);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0);
  endtask
  // Single pulse gate: start, auto disarm, gate flag and interrupt
  task automatic t_gate;
    logic [31:0] q;
    logic [31:0] c1;
    wr(TECR_ADDR_COMPARE, 32'hFFFF);
    wr(TECR_ADDR_COUNT, 32'h0);
    wr(TECR_ADDR_IRQ_MASK, 32'h2);
    wr(TECR_ADDR_GATE, 32'hD0);
    wr(TECR_ADDR_GATE, 32'hD8);
    wr(TECR_ADDR_IRQ_STAT, 32'h2);
    wr(TECR_ADDR_CONTROL, 32'h41);
    repeat (10) @(posedge ref_clk);
    apb(1'b0, TECR_ADDR_COUNT, 32'h0, q);
    chk(q, 32'h0);
    for (int p = 0; p < 2; p++) begin
      gate_pin <= 1'b1;
      repeat (20) @(posedge ref_clk);
      gate_pin <= 1'b0;
      repeat (6) @(posedge ref_clk);
      apb(1'b0, TECR_ADDR_COUNT, 32'h0, q);
      if (p == 0) begin
        c1 = q;
        chk_rng(q, 32'd18, 32'd22);
        apb(1'b0, TECR_ADDR_GATE, 32'h0, q);
        chk({31'h0, q[TECR_GGO_BIT]}, 32'h0);
        apb(1'b0, TECR_ADDR_IRQ_STAT, 32'h0, q);
        chk(q, 32'h2);
        chk({31'h0, irq}, 32'h1);
      end else begin
        chk(q, c1);
      end
    end
    wr(TECR_ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    wr(TECR_ADDR_IRQ_STAT, 32'h2);
    apb(1'b0, TECR_ADDR_IRQ_STAT, 32'h0, q);
    chk(q, 32'h0);
  endtask

  // Verdict and end of run
  task automatic wrap_up;
    $display("Checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {ref_clk, psel, penable, pwrite, ext_clk, osc_clk, sense_clk} = 7'h0;
    {gate_pin, slow, force_trig, collide, last_err} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    n_errors = 0;
    n_checks = 0;
    rst = 1'b1;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_source();
    t_prescale();
    t_trigger();
    t_gate();
    wrap_up();
  end
  // Watchdog against a hang
  initial begin
    repeat (30000) @(posedge ref_clk);
    n_errors++;
    $display("ERROR t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    wrap_up();
  end
endmodule
